/* File: src/cidr_pkg.sv */
// Package of register map, field positions, reset values and timing for the caller-id receiver
package cidr_pkg;
  // Register byte offsets on the bus
  localparam logic [4:0] OFS_MODE_ONE = 5'h00;
  localparam logic [4:0] OFS_MODE_TWO = 5'h04;
  localparam logic [4:0] OFS_STATUS   = 5'h08;
  localparam logic [4:0] OFS_INTR     = 5'h0c;
  localparam logic [4:0] OFS_DATA     = 5'h10;
  // Mode one fields
  localparam int M1_RX_EN      = 7;
  localparam int M1_MARK_MASK  = 6;
  localparam int M1_POL_IEN    = 4;
  localparam int M1_IRQ_LOW    = 3;
  localparam int M1_ALERT_EN   = 0;
  localparam logic [7:0] MODE_ONE_RST = 8'h40;
  // Mode two fields
  localparam int M2_OSC_EN     = 7;
  localparam logic [7:0] MODE_TWO_RST = 8'h80;
  // Status fields
  localparam int ST_LINE_A     = 7;
  localparam int ST_LINE_B     = 6;
  localparam int ST_LOW_BATT   = 5;
  localparam int ST_MARK_SEEN  = 4;
  localparam int ST_OVERRUN    = 3;
  localparam int ST_FRAMING    = 2;
  // Interrupt fields
  localparam int IR_TIMEBASE   = 6;
  localparam int IR_DATA       = 5;
  localparam int IR_LOW_LEVEL  = 4;
  localparam int IR_ALERT      = 1;
  localparam int IR_POLARITY   = 0;
  localparam logic [7:0] IR_RST = 8'h00;
  // Timing
  localparam int CORE_HZ       = 100_000_000;
  localparam int BAUD          = 1200;
  localparam int BIT_CYC_DEF   = CORE_HZ / BAUD;
  localparam int FAST_OSC_HZ   = 3_580_000;
  localparam int ALERT_INIT_PERIODS = 100;
  // Longest init time, rounded down to whole core cycles
  localparam int ALERT_INIT_CYC = (ALERT_INIT_PERIODS * (CORE_HZ / 10_000)) / (FAST_OSC_HZ / 10_000);
  localparam int SLOW_OSC_HZ   = 32_768;
  localparam int LEVEL_MS      = 8;
  localparam int LEVEL_EDGES   = (LEVEL_MS * SLOW_OSC_HZ) / 1000;
  localparam int MARK_BLOCK_BITS_DEF = 10;
  localparam int SYNC_N        = 8;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} cidr_rx_e;
endpackage

/* File: src/cidr_receiver.sv */
// Digital control of the caller-id receiver: modem framing, alert gating, polarity, power-down, registers
// Notes on behaviour
// [RL1] Clearing oscillator enable stops the fast clock and converter outputs.
// [RL2] Host disables detectors, reads interrupts, then clears oscillator enable.
// [RL3] Polarity comparators and slow clock logic stay active in power-down.
// [RL4] Polarity interrupt only when polarity interrupt enable is set.
// [RL5] Line sense A and B read as status bits 7 and 6.
// [RL6] Polarity interrupts run from the slow clock, not the fast clock.
// [RL7] Status bit 5 is high while the battery comparator reports low.
// [RL8] Alert detector initialises within 100 fast periods after reset or enable.
// [RL9] Valid alert tone sets interrupt bit 1 and raises the interrupt.
// [RL10] Alert interrupts blocked while the level detector reports low.
// [RL11] Mode one bit 7 enables the modem receiver.
// [RL12] Mark block after seizure sets mark block seen, status bit 4.
// [RL13] Mark block seen clears whenever the receiver is disabled.
// [RL14] Word is one space start, eight data bits, one mark stop.
// [RL15] With masking, data interrupts only after mark block seen and full word.
// [RL16] Without masking, seizure bits are data; marks alone give no words.
// [RL17] Valid word loads data register, sets interrupt bit 5, drives pin.
// [RL18] Status bit 3 set when a received byte is lost by overrun.
// [RL19] Status bit 2 set on bad start or stop bit.
// [RL20] Host may drop bytes while interrupt bit 4 reads 1.
// [RL21] Polarity, data, alert and timebase events all drive the interrupt pin.
// [RL22] Modem bit timing is 1200 baud.
// [RL23] Reading the interrupt register clears all its flags; the code clears only the flags that the read returned.
// [RL24] Pin active high by default, low with mode one bit 3; released when idle.
// [RL25] Low level bit refreshed every 8 ms from the signal level input.
// [RL26] New word while data unread sets overrun and replaces the byte.
`timescale 1ns/10ps
`default_nettype none
module cidr_receiver
  import cidr_pkg::*;
#(
  parameter int unsigned BIT_CYC         = BIT_CYC_DEF,
  parameter int unsigned MARK_BLOCK_BITS = MARK_BLOCK_BITS_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        line_sense_a,
  input  wire logic        line_sense_b,
  input  wire logic        battery_sense_input,
  input  wire logic        alert_tone_input,
  input  wire logic        signal_level_low,
  input  wire logic        modem_input_pos,
  input  wire logic        modem_input_neg,
  input  wire logic        slow_osc_in,
  input  wire logic        timebase_event,
  output logic             fast_osc_run,
  output logic             adc_enable,
  output logic             irq_out,
  output logic             irq_oe
);
  localparam int CW = $clog2(BIT_CYC + 1);

  // Refuse parameter values the counters cannot serve
  if (BIT_CYC < 8 || MARK_BLOCK_BITS < 1 || MARK_BLOCK_BITS > 255) begin : g_bad_params
    $error("cidr_receiver: unsupported parameter values");
  end

  // Two-flop synchronisers for every pin input
  logic [SYNC_N-1:0] async_in;
  logic [SYNC_N-1:0] meta_r;
  logic [SYNC_N-1:0] sync_r;
  assign async_in = {timebase_event, slow_osc_in, modem_input_neg, modem_input_pos,
                     signal_level_low, alert_tone_input, battery_sense_input, line_sense_a ^ 1'b0};
  generate
    for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (reset) begin
          meta_r[i] <= 1'b0;
          sync_r[i] <= 1'b0;
        end else if (clk_en) begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate
  logic line_b_meta_r;
  logic line_b_sync_r;
  // Line B kept separate so its comparator sense is not folded into the vector
  always_ff @(posedge core_clk) begin
    if (reset) begin
      line_b_meta_r <= 1'b0;
      line_b_sync_r <= 1'b0;
    end else if (clk_en) begin
      line_b_meta_r <= line_sense_b;
      line_b_sync_r <= line_b_meta_r;
    end
  end
  logic line_a_s, batt_s, tone_s, lvl_s, mod_pos_s, mod_neg_s, slow_s, tb_s;
  assign line_a_s  = sync_r[0];
  assign batt_s    = sync_r[1];
  assign tone_s    = sync_r[2];
  assign lvl_s     = sync_r[3];
  assign mod_pos_s = sync_r[4];
  assign mod_neg_s = sync_r[5];
  assign slow_s    = sync_r[6];
  assign tb_s      = sync_r[7];

  // Registers
  logic [7:0] mode_one_r;
  logic [7:0] mode_two_r;
  logic [7:0] intr_r;
  logic [7:0] data_r;
  logic       data_full_r;
  logic       overrun_r;
  logic       framing_r;
  logic       mark_seen_r;
  logic       low_level_r;
  logic       line_a_r;
  logic       line_b_r;
  logic       osc_on;
  assign osc_on = mode_two_r[M2_OSC_EN];

  // Bus slave: one wait cycle, then the access completes
  logic acc_done;
  logic rd_done;
  logic wr_done;
  assign acc_done = clk_en && (avs_read || avs_write) && !avs_waitrequest;
  assign rd_done  = acc_done && avs_read;
  assign wr_done  = acc_done && avs_write && avs_byteenable[0];
  logic [7:0] rd_mux;
  logic [7:0] status_view;
  assign status_view = {line_a_r, line_b_r, batt_s, mark_seen_r, overrun_r, framing_r, 2'b00}; // [RL5] [RL7]
  // Read decode
  always_comb begin
    if (avs_address == OFS_MODE_ONE) begin
      rd_mux = mode_one_r;
    end else if (avs_address == OFS_MODE_TWO) begin
      rd_mux = mode_two_r;
    end else if (avs_address == OFS_STATUS) begin
      rd_mux = status_view;
    end else if (avs_address == OFS_INTR) begin
      rd_mux = {intr_r[7:5], low_level_r, intr_r[3:0]};
    end else if (avs_address == OFS_DATA) begin
      rd_mux = data_r;
    end else begin
      rd_mux = 8'h00;
    end
  end
  // Handshake and read data; unmapped addresses read zero and ignore writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if (clk_en) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= {24'h0, rd_mux};
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end
  logic rd_intr, rd_status, rd_data;
  assign rd_intr   = rd_done && avs_address == OFS_INTR;
  assign rd_status = rd_done && avs_address == OFS_STATUS;
  assign rd_data   = rd_done && avs_address == OFS_DATA;

  // Mode registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_one_r <= MODE_ONE_RST;
      mode_two_r <= MODE_TWO_RST;
    end else if (wr_done) begin
      if (avs_address == OFS_MODE_ONE) begin
        mode_one_r <= avs_writedata[7:0];
      end else if (avs_address == OFS_MODE_TWO) begin
        mode_two_r <= avs_writedata[7:0];
      end
    end
  end

  // Power-down: fast oscillator and converter follow the enable bit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fast_osc_run <= 1'b1;
      adc_enable   <= 1'b1;
    end else if (clk_en) begin
      fast_osc_run <= osc_on; // [RL1]
      adc_enable   <= osc_on; // [RL1]
    end
  end

  // Slow clock edge finder; polarity and level logic ignore the fast clock enable
  logic slow_d_r;
  logic slow_edge;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      slow_d_r <= 1'b0;
    end else if (clk_en) begin
      slow_d_r <= slow_s;
    end
  end
  assign slow_edge = slow_s && !slow_d_r;

  // Polarity status captured on slow edges, always running
  logic pol_event;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      line_a_r <= 1'b0;
      line_b_r <= 1'b0;
    end else if (clk_en && slow_edge) begin
      line_a_r <= line_a_s;      // [RL3] [RL6]
      line_b_r <= line_b_sync_r; // [RL3] [RL6]
    end
  end
  // A falls to 0 or B rises to 1 gives a polarity event
  assign pol_event = slow_edge && mode_one_r[M1_POL_IEN] &&
                     ((line_a_r && !line_a_s) || (!line_b_r && line_b_sync_r)); // [RL4] [RL6]

  // Level indication refreshed once per 8 ms of slow clock
  logic [8:0] lvl_cnt_r;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lvl_cnt_r   <= 9'h0;
      low_level_r <= 1'b0;
    end else if (clk_en && slow_edge) begin
      if (lvl_cnt_r == 9'(LEVEL_EDGES - 1)) begin
        lvl_cnt_r   <= 9'h0;
        low_level_r <= lvl_s; // [RL25]
      end else begin
        lvl_cnt_r <= lvl_cnt_r + 9'h1;
      end
    end
  end

  // Alert detector init window after reset or enable rising
  logic        alert_en_d_r;
  logic [11:0] alert_init_r;
  logic        tone_d_r;
  logic        alert_event;
  logic        alert_en;
  assign alert_en = mode_one_r[M1_ALERT_EN] && osc_on;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      alert_en_d_r <= 1'b0;
      alert_init_r <= 12'(ALERT_INIT_CYC);
      tone_d_r     <= 1'b0;
    end else if (clk_en) begin
      alert_en_d_r <= alert_en;
      tone_d_r     <= tone_s;
      if (alert_en && !alert_en_d_r) begin
        alert_init_r <= 12'(ALERT_INIT_CYC); // [RL8]
      end else if (alert_init_r != 12'h0 && osc_on) begin
        alert_init_r <= alert_init_r - 12'h1; // [RL8]
      end
    end
  end
  assign alert_event = alert_en && alert_init_r == 12'h0 && tone_s && !tone_d_r && !low_level_r; // [RL9] [RL10]

  // Timebase edge passes straight to its interrupt flag
  logic tb_d_r;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tb_d_r <= 1'b0;
    end else if (clk_en) begin
      tb_d_r <= tb_s;
    end
  end

  // Modem receiver: mark is pos high with neg low
  cidr_rx_e   rx_state_r;
  logic [CW-1:0] bit_cnt_r;
  logic [2:0] bit_idx_r;
  logic [7:0] shift_r;
  logic [7:0] mark_bits_r;
  logic       rx_prev_r;
  logic       rx_bit;
  logic       rx_run;
  logic       word_ok;
  logic       word_bad;
  logic       deliver;
  assign rx_bit = mod_pos_s && !mod_neg_s;
  assign rx_run = mode_one_r[M1_RX_EN] && osc_on; // [RL11]
  // Seizure garbage is hidden until the mark block when masking
  assign deliver = mark_seen_r || !mode_one_r[M1_MARK_MASK]; // [RL15] [RL16]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_state_r  <= RX_IDLE;
      bit_cnt_r   <= '0;
      bit_idx_r   <= 3'h0;
      shift_r     <= 8'h0;
      mark_bits_r <= 8'h0;
      rx_prev_r   <= 1'b1;
      word_ok     <= 1'b0;
      word_bad    <= 1'b0;
    end else if (clk_en) begin
      word_ok  <= 1'b0;
      word_bad <= 1'b0;
      if (!rx_run) begin
        rx_state_r  <= RX_IDLE;
        bit_cnt_r   <= '0;
        mark_bits_r <= 8'h0;
        rx_prev_r   <= 1'b1;
      end else begin
        rx_prev_r <= rx_bit;
        case (rx_state_r)
          RX_IDLE: begin
            if (rx_prev_r && !rx_bit) begin
              rx_state_r  <= RX_START; // [RL14]
              bit_cnt_r   <= '0;
              mark_bits_r <= 8'h0;
            end else if (!rx_bit) begin
              bit_cnt_r   <= '0;
              mark_bits_r <= 8'h0;
            end else if (bit_cnt_r == CW'(BIT_CYC - 1)) begin
              // Marks alone never start a word, they only count toward the block
              bit_cnt_r <= '0;
              if (mark_bits_r != 8'hff) begin
                mark_bits_r <= mark_bits_r + 8'h1; // [RL16]
              end
            end else begin
              bit_cnt_r <= bit_cnt_r + CW'(1);
            end
          end
          RX_START: begin
            if (bit_cnt_r == CW'(BIT_CYC / 2 - 1)) begin
              bit_cnt_r <= '0;
              if (!rx_bit) begin
                rx_state_r <= RX_DATA;
                bit_idx_r  <= 3'h0;
              end else begin
                rx_state_r <= RX_IDLE;
                word_bad   <= 1'b1; // [RL19]
              end
            end else begin
              bit_cnt_r <= bit_cnt_r + CW'(1);
            end
          end
          RX_DATA: begin
            if (bit_cnt_r == CW'(BIT_CYC - 1)) begin
              bit_cnt_r <= '0;
              shift_r   <= {rx_bit, shift_r[7:1]}; // [RL14] [RL22]
              bit_idx_r <= bit_idx_r + 3'h1;
              if (bit_idx_r == 3'h7) begin
                rx_state_r <= RX_STOP;
              end
            end else begin
              bit_cnt_r <= bit_cnt_r + CW'(1);
            end
          end
          RX_STOP: begin
            if (bit_cnt_r == CW'(BIT_CYC - 1)) begin
              bit_cnt_r  <= '0;
              rx_state_r <= RX_IDLE;
              word_ok    <= rx_bit;  // [RL14]
              word_bad   <= !rx_bit; // [RL19]
            end else begin
              bit_cnt_r <= bit_cnt_r + CW'(1);
            end
          end
          default: rx_state_r <= RX_IDLE;
        endcase
      end
    end
  end

  // Mark block flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mark_seen_r <= 1'b0;
    end else if (clk_en) begin
      if (!mode_one_r[M1_RX_EN]) begin
        mark_seen_r <= 1'b0; // [RL13]
      end else if (mark_bits_r == 8'(MARK_BLOCK_BITS)) begin
        mark_seen_r <= 1'b1; // [RL12]
      end
    end
  end

  // Data register and its full, overrun and framing flags; a set beats a read clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_r      <= 8'h0;
      data_full_r <= 1'b0;
      overrun_r   <= 1'b0;
      framing_r   <= 1'b0;
    end else if (clk_en) begin
      if (word_ok && deliver) begin
        data_r      <= shift_r; // [RL17] [RL26]
        data_full_r <= 1'b1;
      end else if (rd_data) begin
        data_full_r <= 1'b0;
      end
      if (word_ok && deliver && data_full_r && !rd_data) begin
        overrun_r <= 1'b1; // [RL18] [RL26]
      end else if (rd_status && avs_readdata[ST_OVERRUN]) begin
        overrun_r <= 1'b0; // Only cleared once the host has seen it
      end
      if (word_bad && deliver) begin
        framing_r <= 1'b1; // [RL19]
      end else if (rd_status && avs_readdata[ST_FRAMING]) begin
        framing_r <= 1'b0; // Only cleared once the host has seen it
      end
    end
  end

  // Interrupt flags: hardware sets, read clears only the flags it returned, so a set in the wait cycle survives
  logic [7:0] intr_set;
  assign intr_set = {1'b0, tb_s && !tb_d_r, word_ok && deliver, 1'b0, 2'b00,
                     alert_event, pol_event}; // [RL21]
  always_ff @(posedge core_clk) begin
    if (reset) begin
      intr_r <= IR_RST;
    end else if (clk_en) begin
      intr_r <= intr_set | (rd_intr ? (intr_r & ~avs_readdata[7:0]) : intr_r); // [RL23] [RL9] [RL17]
    end
  end

  // Pin drive: level follows polarity bit, released when nothing pending
  logic irq_active;
  assign irq_active = |intr_r;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else if (clk_en) begin
      irq_oe  <= irq_active;                             // [RL24] [RL21]
      irq_out <= irq_active ^ mode_one_r[M1_IRQ_LOW];    // [RL24]
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || !clk_en);

  property p_osc_follow;
    $fell(osc_on) |=> !fast_osc_run && !adc_enable;
  endproperty
  a_osc_follow: assert property (p_osc_follow) else $error("oscillator not stopped"); // [RL1]

  property p_pol_gate;
    !mode_one_r[M1_POL_IEN] && !intr_r[IR_POLARITY] |=> !intr_r[IR_POLARITY];
  endproperty
  a_pol_gate: assert property (p_pol_gate) else $error("polarity interrupt without enable"); // [RL4]

  property p_alert_level;
    low_level_r && !intr_r[IR_ALERT] |=> !intr_r[IR_ALERT];
  endproperty
  a_alert_level: assert property (p_alert_level) else $error("alert interrupt at low level"); // [RL10]

  // Cycles spent initialising since reset or enable; too long for a delay range
  logic [11:0] alert_wait_r;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      alert_wait_r <= 12'h0;
    end else if (clk_en) begin
      if (alert_en && !alert_en_d_r) begin
        alert_wait_r <= 12'h0;
      end else if (alert_init_r != 12'h0 && osc_on && alert_wait_r != 12'hfff) begin
        alert_wait_r <= alert_wait_r + 12'h1;
      end
    end
  end
  property p_alert_init;
    alert_wait_r <= 12'(ALERT_INIT_CYC);
  endproperty
  a_alert_init: assert property (p_alert_init) else $error("alert init too long"); // [RL8]

  property p_mark_clear;
    !mode_one_r[M1_RX_EN] |=> !mark_seen_r;
  endproperty
  a_mark_clear: assert property (p_mark_clear) else $error("mark flag kept while disabled"); // [RL13]

  property p_word_load;
    word_ok && deliver |=> data_r == $past(shift_r) && intr_r[IR_DATA] ##1 irq_oe;
  endproperty
  a_word_load: assert property (p_word_load) else $error("word not delivered"); // [RL17]

  property p_mask;
    word_ok && mode_one_r[M1_MARK_MASK] && !mark_seen_r |=> !$rose(intr_r[IR_DATA]);
  endproperty
  a_mask: assert property (p_mask) else $error("data interrupt before mark block"); // [RL15]

  property p_overrun;
    word_ok && deliver && data_full_r && !rd_data |=> overrun_r;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // [RL18]

  property p_intr_clear;
    rd_intr && intr_set == 8'h00 && $stable(intr_r) |=> intr_r == 8'h00;
  endproperty
  a_intr_clear: assert property (p_intr_clear) else $error("interrupt read did not clear"); // [RL23]

  property p_irq_level;
    irq_oe |-> irq_out == !mode_one_r[M1_IRQ_LOW] || $changed(mode_one_r);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt pin level wrong"); // [RL24]

  c_word:    cover property (word_ok && deliver);
  c_frame:   cover property (word_bad && deliver);
  c_alert:   cover property (alert_event);
  c_polar:   cover property (pol_event);
endmodule
`default_nettype wire

/* File: test/cidr_modem_model.sv */
// Modem line sender model driving demodulated mark and space bits
`timescale 1ns/10ps
`default_nettype none
module cidr_modem_model #(
  parameter int unsigned BIT_CYC = 16
) (
  input  wire logic core_clk,
  output var  logic modem_input_pos,
  output var  logic modem_input_neg
);
  // Line rests at mark
  initial begin
    modem_input_pos = 1'b1;
    modem_input_neg = 1'b0;
  end
  // One bit period; caller stands on a rising edge, so periods abut
  task automatic send_bit(input logic b);
    modem_input_pos <= b;
    modem_input_neg <= ~b;
    repeat (BIT_CYC) @(posedge core_clk);
  endtask
  // Space start, eight bits LSB first, chosen stop level
  task automatic send_word(input logic [7:0] d, input logic stop);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) send_bit(d[i]);
    send_bit(stop);
  endtask
  // Idle stretch of marks
  task automatic marks(input int n);
    repeat (n) send_bit(1'b1);
  endtask
endmodule
`default_nettype wire

/* File: test/test_cidr_receiver.sv */
// Self-checking bench for the caller-id receiver
`timescale 1ns/10ps
`default_nettype none
module test_cidr_receiver;
  import cidr_pkg::*;
  localparam int BC = 16;
  logic        core_clk, reset, clk_en, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        line_sense_a, line_sense_b, battery_sense_input, alert_tone_input;
  logic        signal_level_low, modem_input_pos, modem_input_neg, slow_osc_in;
  logic        timebase_event, fast_osc_run, adc_enable, irq_out, irq_oe;
  int          fails, num_checks;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0]  b1, b2, b3;

  cidr_receiver #(.BIT_CYC(BC), .MARK_BLOCK_BITS(3)) dut (
    .core_clk, .reset, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .line_sense_a, .line_sense_b,
    .battery_sense_input, .alert_tone_input, .signal_level_low, .modem_input_pos,
    .modem_input_neg, .slow_osc_in, .timebase_event, .fast_osc_run, .adc_enable,
    .irq_out, .irq_oe);
  cidr_modem_model #(.BIT_CYC(BC)) modem (.core_clk, .modem_input_pos, .modem_input_neg);

  // Clocks; slow clock free running with its own phase
  always #5 core_clk = ~core_clk;
  initial begin
    slow_osc_in = 1'b0;
    #3;
    forever #40 slow_osc_in = ~slow_osc_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Avalon access; an idle edge first so no strobe is set twice in one step
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    @(posedge core_clk);
    // Only the watchdog ends a wait that never completes
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  // Note the masked expectation, then read
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    msk_q.push_back(m);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Read data taken at the completing edge only
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
  end

  // Hang guard
  initial begin
    #500000;
    fails++;
    complete_run();
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    line_sense_a = 1'b1;
    line_sense_b = 1'b0;
    battery_sense_input = 1'b0;
    alert_tone_input = 1'b0;
    signal_level_low = 1'b0;
    timebase_event = 1'b0;
    void'($urandom(32'hc21fe4e2));
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    b3 = 8'($urandom);
    cyc(4);
    reset <= 1'b0;
    // Reset values and an unmapped place
    rd(OFS_MODE_ONE, 32'hff, {24'h0, MODE_ONE_RST});
    rd(OFS_MODE_TWO, 32'hff, {24'h0, MODE_TWO_RST});
    rd(OFS_INTR, 32'hff, {24'h0, IR_RST});
    rd(5'h14, 32'hffffffff, 32'h0);
    check(irq_oe, 1'b0);
    // Comparator levels and battery
    line_sense_b <= 1'b1;
    battery_sense_input <= 1'b1;
    cyc(40);
    rd(OFS_STATUS, 32'he0, 32'he0);
    // Polarity event while not enabled, then enabled
    line_sense_a <= 1'b0;
    cyc(40);
    rd(OFS_INTR, 32'h1, 32'h0);
    line_sense_a <= 1'b1;
    wr(OFS_MODE_ONE, 8'h50);
    cyc(40);
    line_sense_a <= 1'b0;
    cyc(40);
    rd(OFS_INTR, 32'h1, 32'h1);
    rd(OFS_INTR, 32'h1, 32'h0);
    // Seizure with masking gives no data interrupt
    wr(OFS_MODE_ONE, 8'hc0);
    for (int i = 0; i < 20; i++) modem.send_bit(i[0]);
    rd(OFS_INTR, 32'h20, 32'h0);
    modem.marks(5);
    rd(OFS_STATUS, 32'h10, 32'h10);
    modem.send_word(b1, 1'b1);
    cyc(4);
    check(irq_oe, 1'b1);
    check(irq_out, 1'b1);
    rd(OFS_INTR, 32'h20, 32'h20);
    rd(OFS_DATA, 32'hffffffff, {24'h0, b1});
    // Two words unread: overrun keeps the newest
    modem.send_word(b2, 1'b1);
    modem.send_word(b3, 1'b1);
    cyc(4);
    rd(OFS_STATUS, 32'h08, 32'h08);
    rd(OFS_DATA, 32'hff, {24'h0, b3});
    // Space where the stop mark belongs
    modem.send_word(b1, 1'b0);
    modem.marks(2);
    rd(OFS_STATUS, 32'h04, 32'h04);
    wr(OFS_MODE_ONE, 8'h00);
    rd(OFS_STATUS, 32'h10, 32'h0);
    rd(OFS_INTR, 32'h20, 32'h20);
    // No masking, pin active low
    wr(OFS_MODE_ONE, 8'h88);
    modem.send_word(b2, 1'b1);
    cyc(4);
    check(irq_oe, 1'b1);
    check(irq_out, 1'b0);
    rd(OFS_DATA, 32'hff, {24'h0, b2});
    rd(OFS_INTR, 32'h20, 32'h20);
    modem.marks(4);
    rd(OFS_INTR, 32'h20, 32'h0);
    check(irq_oe, 1'b0);
    // Alert tone after detector init
    wr(OFS_MODE_ONE, 8'h01);
    cyc(ALERT_INIT_CYC + 10);
    alert_tone_input <= 1'b1;
    cyc(6);
    alert_tone_input <= 1'b0;
    rd(OFS_INTR, 32'h2, 32'h2);
    // Low level blocks the tone
    signal_level_low <= 1'b1;
    cyc(LEVEL_EDGES * 8 + 100);
    rd(OFS_INTR, 32'h10, 32'h10);
    alert_tone_input <= 1'b1;
    cyc(6);
    alert_tone_input <= 1'b0;
    rd(OFS_INTR, 32'h2, 32'h0);
    timebase_event <= 1'b1;
    cyc(4);
    timebase_event <= 1'b0;
    rd(OFS_INTR, 32'h40, 32'h40);
    // Power-down in the required order
    wr(OFS_MODE_ONE, 8'h10);
    rd(OFS_INTR, 32'h23, 32'h0);
    wr(OFS_MODE_TWO, 8'h00);
    cyc(2);
    check(fast_osc_run, 1'b0);
    check(adc_enable, 1'b0);
    line_sense_a <= 1'b1;
    cyc(40);
    line_sense_a <= 1'b0;
    cyc(40);
    rd(OFS_INTR, 32'h1, 32'h1);
    rd(OFS_STATUS, 32'h80, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
